/* ssp_pkg.sv */
// constants shared by the serial port pin-routing block
package ssp_pkg;

    // ==========================================================
    // register offsets (byte addresses on the register bus)
    localparam logic [7:0] SSP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SSP_OFF_DIV = 8'h04;
    localparam logic [7:0] SSP_OFF_GPIO_DIR = 8'h08;
    localparam logic [7:0] SSP_OFF_GPIO_OUT = 8'h0C;
    localparam logic [7:0] SSP_OFF_GPIO_IN = 8'h10;
    localparam logic [7:0] SSP_OFF_TX0 = 8'h14;
    localparam logic [7:0] SSP_OFF_TX1 = 8'h18;
    localparam logic [7:0] SSP_OFF_TX2 = 8'h1C;
    localparam logic [7:0] SSP_OFF_RX = 8'h20;
    localparam logic [7:0] SSP_OFF_STATUS = 8'h24;

    // ==========================================================
    // control register field positions
    localparam int SSP_CTRL_W = 12;
    localparam int SSP_CB_EN = 0;          // port in use
    localparam int SSP_CB_SYNC = 1;        // synchronous mode
    localparam int SSP_CB_CLK_OUT = 2;     // bit clock driven out
    localparam int SSP_CB_FS_OUT = 3;      // pin two frame sync driven out
    localparam int SSP_CB_RXCLK_OUT = 4;   // async: pin zero rx clock driven out
    localparam int SSP_CB_RXFS_OUT = 5;    // async: pin one rx frame sync driven out
    localparam int SSP_CB_P0_TX = 6;       // sync: pin zero is second transmitter
    localparam int SSP_CB_P1_TX = 7;       // sync: pin one is third transmitter
    localparam int SSP_CB_F0_OUT = 8;      // sync: flag 0 is an output
    localparam int SSP_CB_F1_OUT = 9;      // sync: flag 1 is an output
    localparam int SSP_CB_F0_VAL = 10;     // flag 0 output value
    localparam int SSP_CB_F1_VAL = 11;     // flag 1 output value
    // fields frozen while the port is enabled
    localparam logic [11:0] SSP_CTRL_LOCK = 12'h3FE;

    // status register field positions
    localparam int SSP_SB_TX_EMPTY = 0;
    localparam int SSP_SB_RX_FULL = 1;
    localparam int SSP_SB_FLAG0_IN = 2;
    localparam int SSP_SB_FLAG1_IN = 3;

    // ==========================================================
    // reset values
    localparam logic [11:0] SSP_CTRL_RST = 12'h000;
    localparam logic [7:0] SSP_DIV_RST = 8'h0F;
    localparam logic [5:0] SSP_GPIO_RST = 6'h00;
    localparam logic [15:0] SSP_DATA_RST = 16'h0000;

    // ==========================================================
    // word framing
    localparam int SSP_WORD_W = 16;
    localparam logic [3:0] SSP_BIT_LAST = 4'hF;

    // pin indices in the six-bit pin vectors
    localparam int SSP_PIN_TXD = 0;
    localparam int SSP_PIN_RXD = 1;
    localparam int SSP_PIN_CLK = 2;
    localparam int SSP_PIN_C0 = 3;
    localparam int SSP_PIN_C1 = 4;
    localparam int SSP_PIN_C2 = 5;

endpackage

/* ssp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module ssp_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

/* ssp_pin_route.sv */
// serial port pin routing with framing, shifters and register slave
// Behaviour
// - tx data pin drives transmit shifter bits
// - rx data pin shifts into receive shifter
// - bit clock pin times transmitter, in or out
// - bit clock free or gated; sync shares it
// - async: pin zero is receive clock
// - sync: pin zero is tx two or flag0
// - async: pin one is receive frame sync
// - sync: pin one is tx three or flag1
// - sync: pin two is shared frame sync
// - async: pin two frames transmitter only
// - pin two output drives internal frame sync
// - unused port: six pins act as GPIO
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module ssp_pin_route (
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit data pin
    input wire logic ser_tx_data_in,
    output logic ser_tx_data_out,
    output logic ser_tx_data_oe,
    // receive data pin
    input wire logic ser_rx_data_in,
    output logic ser_rx_data_out,
    output logic ser_rx_data_oe,
    // bit clock pin
    input wire logic ser_bit_clk_in,
    output logic ser_bit_clk_out,
    output logic ser_bit_clk_oe,
    // control pin zero
    input wire logic ctrl_pin_zero_in,
    output logic ctrl_pin_zero_out,
    output logic ctrl_pin_zero_oe,
    // control pin one
    input wire logic ctrl_pin_one_in,
    output logic ctrl_pin_one_out,
    output logic ctrl_pin_one_oe,
    // control pin two
    input wire logic ctrl_pin_two_in,
    output logic ctrl_pin_two_out,
    output logic ctrl_pin_two_oe
);
    import ssp_pkg::*;

    // ==========================================================
    // pin input synchronisers
    logic [5:0] pin_raw; // raw pin levels
    logic [5:0] pin_s; // pin levels after two flops

    assign pin_raw = {ctrl_pin_two_in, ctrl_pin_one_in, ctrl_pin_zero_in,
                      ser_bit_clk_in, ser_rx_data_in, ser_tx_data_in};

    ssp_sync #(.WIDTH(6)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // ==========================================================
    // registers
    logic [11:0] ctrl_reg; // mode and pin functions
    logic [7:0] div_reg; // half period of generated clock minus one
    logic [5:0] gpio_dir_reg; // 1 = drive pin when port unused
    logic [5:0] gpio_out_reg; // gpio output levels
    logic [15:0] tx0_reg, tx1_reg, tx2_reg; // words for the three transmitters
    logic [15:0] rx_reg; // last received word
    logic tx_empty_reg; // tx0 word moved to shifter
    logic rx_full_reg; // word waiting in rx_reg

    // control fields
    wire port_en = ctrl_reg[SSP_CB_EN];
    wire sync_mode = ctrl_reg[SSP_CB_SYNC];
    wire clk_out = ctrl_reg[SSP_CB_CLK_OUT];
    wire fs_out = ctrl_reg[SSP_CB_FS_OUT];
    wire rxclk_out = ctrl_reg[SSP_CB_RXCLK_OUT];
    wire rxfs_out = ctrl_reg[SSP_CB_RXFS_OUT];

    // ==========================================================
    // bus decode; one wait state because answers come from flops
    wire acc = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire wr = done & pwrite;
    wire rd = done & ~pwrite;
    wire hit_ctrl = (paddr == SSP_OFF_CTRL);
    wire hit_div = (paddr == SSP_OFF_DIV);
    wire hit_dir = (paddr == SSP_OFF_GPIO_DIR);
    wire hit_gout = (paddr == SSP_OFF_GPIO_OUT);
    wire hit_gin = (paddr == SSP_OFF_GPIO_IN);
    wire hit_tx0 = (paddr == SSP_OFF_TX0);
    wire hit_tx1 = (paddr == SSP_OFF_TX1);
    wire hit_tx2 = (paddr == SSP_OFF_TX2);
    wire hit_rx = (paddr == SSP_OFF_RX);
    wire hit_st = (paddr == SSP_OFF_STATUS);
    wire hit_any = hit_ctrl | hit_div | hit_dir | hit_gout | hit_gin | hit_tx0 |
                   hit_tx1 | hit_tx2 | hit_rx | hit_st;
    // read-only registers refuse writes
    wire bad = ~hit_any | (pwrite & (hit_gin | hit_rx | hit_st));

    // pin functions and mode may change only while the port is off
    wire [11:0] ctrl_lock = port_en ? SSP_CTRL_LOCK : 12'h000;
    wire [11:0] ctrl_wval = (pwdata[11:0] & ~ctrl_lock) | (ctrl_reg & ctrl_lock);

    wire [31:0] rd_mux =
        hit_ctrl ? {20'h00000, ctrl_reg} :
        hit_div ? {24'h000000, div_reg} :
        hit_dir ? {26'h0000000, gpio_dir_reg} :
        hit_gout ? {26'h0000000, gpio_out_reg} :
        hit_gin ? {26'h0000000, pin_s} :
        hit_tx0 ? {16'h0000, tx0_reg} :
        hit_tx1 ? {16'h0000, tx1_reg} :
        hit_tx2 ? {16'h0000, tx2_reg} :
        hit_rx ? {16'h0000, rx_reg} :
        hit_st ? {28'h0000000, pin_s[SSP_PIN_C1], pin_s[SSP_PIN_C0],
                  rx_full_reg, tx_empty_reg} :
        32'h00000000;

    // bus answer flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= acc;
            pslverr <= acc & bad;
            prdata <= (acc & ~pwrite & ~bad) ? rd_mux : 32'h00000000;
        end
    end

    // ==========================================================
    // clock generator for driven bit clocks
    logic [7:0] gen_cnt_reg; // cycles already spent in this half period
    logic gen_clk_reg; // generated bit clock level

    // runs only while enabled, so a driven clock is gated when idle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gen_cnt_reg <= 8'h00;
            gen_clk_reg <= 1'b0;
        end else if (!port_en) begin
            gen_cnt_reg <= 8'h00;
            gen_clk_reg <= 1'b0;
        end else if (gen_cnt_reg == div_reg) begin
            gen_cnt_reg <= 8'h00;
            gen_clk_reg <= ~gen_clk_reg;
        end else begin
            gen_cnt_reg <= gen_cnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // clock and frame sync selection
    logic tx_clk_d_reg, rx_clk_d_reg; // previous clock levels for edges
    logic [3:0] tx_cnt_reg, rx_cnt_reg; // bit position in word
    logic tx_fs_reg, rx_fs_reg; // generated frame syncs
    logic rx_framed_reg; // receiver has seen a frame start
    logic [15:0] sh0_reg, sh1_reg, sh2_reg, rsh_reg; // shifters

    // sampled pin edges only, so external clocks may stop between frames
    wire tx_clk = clk_out ? gen_clk_reg : pin_s[SSP_PIN_CLK];
    wire rx_clk = sync_mode ? tx_clk :
                  (rxclk_out ? gen_clk_reg : pin_s[SSP_PIN_C0]);
    wire tx_rise = tx_clk & ~tx_clk_d_reg;
    wire rx_rise = rx_clk & ~rx_clk_d_reg;
    wire rx_fall = ~rx_clk & rx_clk_d_reg;

    // transmitter frames on pin two in both modes
    wire tx_start = fs_out ? (tx_cnt_reg == SSP_BIT_LAST) : pin_s[SSP_PIN_C2];
    // receiver shares pin two in sync mode, uses pin one otherwise
    wire rx_start = sync_mode ? tx_start :
                    (rxfs_out ? (rx_cnt_reg == SSP_BIT_LAST) : pin_s[SSP_PIN_C1]);
    wire rx_bit = pin_s[SSP_PIN_RXD];
    wire rx_cap = port_en & rx_fall & rx_framed_reg & (rx_cnt_reg == SSP_BIT_LAST);
    wire tx_load = port_en & tx_rise & tx_start;

    // edge history
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_clk_d_reg <= 1'b0;
            rx_clk_d_reg <= 1'b0;
        end else begin
            tx_clk_d_reg <= tx_clk;
            rx_clk_d_reg <= rx_clk;
        end
    end

    // ==========================================================
    // transmit section: shift out on rising bit clock, msb first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt_reg <= SSP_BIT_LAST;
            tx_fs_reg <= 1'b0;
            sh0_reg <= SSP_DATA_RST;
            sh1_reg <= SSP_DATA_RST;
            sh2_reg <= SSP_DATA_RST;
        end else if (!port_en) begin
            // parked so the first edge after enable starts a word when frame sync is driven out
            tx_cnt_reg <= SSP_BIT_LAST;
            tx_fs_reg <= 1'b0;
        end else if (tx_rise) begin
            if (tx_start) begin
                tx_cnt_reg <= 4'h0;
                tx_fs_reg <= fs_out;
                sh0_reg <= tx0_reg;
                sh1_reg <= tx1_reg;
                sh2_reg <= tx2_reg;
            end else begin
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                tx_fs_reg <= 1'b0;
                sh0_reg <= {sh0_reg[14:0], 1'b0};
                sh1_reg <= {sh1_reg[14:0], 1'b0};
                sh2_reg <= {sh2_reg[14:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // receive section: count on rising edge, sample on falling edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt_reg <= SSP_BIT_LAST;
            rx_fs_reg <= 1'b0;
            rx_framed_reg <= 1'b0;
            rsh_reg <= SSP_DATA_RST;
        end else if (!port_en) begin
            rx_cnt_reg <= SSP_BIT_LAST;
            rx_fs_reg <= 1'b0;
            rx_framed_reg <= 1'b0;
        end else begin
            if (rx_rise) begin
                rx_cnt_reg <= rx_start ? 4'h0 : rx_cnt_reg + 4'h1;
                rx_fs_reg <= rx_start & rxfs_out & ~sync_mode;
                rx_framed_reg <= rx_framed_reg | rx_start;
            end
            if (rx_fall) begin
                rsh_reg <= {rsh_reg[14:0], rx_bit};
            end
        end
    end

    // ==========================================================
    // software registers; hardware set beats software clear on flags
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= SSP_CTRL_RST;
            div_reg <= SSP_DIV_RST;
            gpio_dir_reg <= SSP_GPIO_RST;
            gpio_out_reg <= SSP_GPIO_RST;
            tx0_reg <= SSP_DATA_RST;
            tx1_reg <= SSP_DATA_RST;
            tx2_reg <= SSP_DATA_RST;
            rx_reg <= SSP_DATA_RST;
            tx_empty_reg <= 1'b1;
            rx_full_reg <= 1'b0;
        end else begin
            if (wr & hit_ctrl) begin
                ctrl_reg <= ctrl_wval;
            end
            if (wr & hit_div) begin
                div_reg <= pwdata[7:0];
            end
            if (wr & hit_dir) begin
                gpio_dir_reg <= pwdata[5:0];
            end
            if (wr & hit_gout) begin
                gpio_out_reg <= pwdata[5:0];
            end
            if (wr & hit_tx0) begin
                tx0_reg <= pwdata[15:0];
            end
            if (wr & hit_tx1) begin
                tx1_reg <= pwdata[15:0];
            end
            if (wr & hit_tx2) begin
                tx2_reg <= pwdata[15:0];
            end
            if (rx_cap) begin
                rx_reg <= {rsh_reg[14:0], rx_bit};
            end
            tx_empty_reg <= (tx_empty_reg & ~(wr & hit_tx0)) | tx_load;
            rx_full_reg <= (rx_full_reg & ~(rd & hit_rx)) | rx_cap;
        end
    end

    // ==========================================================
    // pin muxing; each pin falls back to gpio while the port is off
    logic [5:0] pin_out_next, pin_oe_next; // next pin drive
    logic [5:0] pin_out_reg, pin_oe_reg; // registered pin drive

    always_comb begin
        if (!port_en) begin
            pin_out_next = gpio_out_reg;
            pin_oe_next = gpio_dir_reg;
        end else begin
            pin_out_next = 6'h00;
            pin_oe_next = 6'h00;
            pin_out_next[SSP_PIN_TXD] = sh0_reg[15];
            pin_oe_next[SSP_PIN_TXD] = 1'b1;
            // receive data pin stays an input
            pin_out_next[SSP_PIN_CLK] = gen_clk_reg;
            pin_oe_next[SSP_PIN_CLK] = clk_out;
            pin_out_next[SSP_PIN_C2] = tx_fs_reg;
            pin_oe_next[SSP_PIN_C2] = fs_out;
            if (sync_mode) begin
                // pin zero: second transmitter or flag 0
                if (ctrl_reg[SSP_CB_P0_TX]) begin
                    pin_out_next[SSP_PIN_C0] = sh1_reg[15];
                    pin_oe_next[SSP_PIN_C0] = 1'b1;
                end else begin
                    pin_out_next[SSP_PIN_C0] = ctrl_reg[SSP_CB_F0_VAL];
                    pin_oe_next[SSP_PIN_C0] = ctrl_reg[SSP_CB_F0_OUT];
                end
                // pin one: third transmitter or flag 1
                if (ctrl_reg[SSP_CB_P1_TX]) begin
                    pin_out_next[SSP_PIN_C1] = sh2_reg[15];
                    pin_oe_next[SSP_PIN_C1] = 1'b1;
                end else begin
                    pin_out_next[SSP_PIN_C1] = ctrl_reg[SSP_CB_F1_VAL];
                    pin_oe_next[SSP_PIN_C1] = ctrl_reg[SSP_CB_F1_OUT];
                end
            end else begin
                // receive clock and receive frame sync
                pin_out_next[SSP_PIN_C0] = gen_clk_reg;
                pin_oe_next[SSP_PIN_C0] = rxclk_out;
                pin_out_next[SSP_PIN_C1] = rx_fs_reg;
                pin_oe_next[SSP_PIN_C1] = rxfs_out;
            end
        end
    end

    // pin drive flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_reg <= 6'h00;
            pin_oe_reg <= 6'h00;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign ser_tx_data_out = pin_out_reg[SSP_PIN_TXD];
    assign ser_tx_data_oe = pin_oe_reg[SSP_PIN_TXD];
    assign ser_rx_data_out = pin_out_reg[SSP_PIN_RXD];
    assign ser_rx_data_oe = pin_oe_reg[SSP_PIN_RXD];
    assign ser_bit_clk_out = pin_out_reg[SSP_PIN_CLK];
    assign ser_bit_clk_oe = pin_oe_reg[SSP_PIN_CLK];
    assign ctrl_pin_zero_out = pin_out_reg[SSP_PIN_C0];
    assign ctrl_pin_zero_oe = pin_oe_reg[SSP_PIN_C0];
    assign ctrl_pin_one_out = pin_out_reg[SSP_PIN_C1];
    assign ctrl_pin_one_oe = pin_oe_reg[SSP_PIN_C1];
    assign ctrl_pin_two_out = pin_out_reg[SSP_PIN_C2];
    assign ctrl_pin_two_oe = pin_oe_reg[SSP_PIN_C2];

endmodule

`default_nettype wire

/* ssp_pin_route_assertions.sv */
// concurrent checks on the ports of the serial port pin-routing block
`timescale 1ns/10ps
`default_nettype none

module ssp_pin_route_assertions
    import ssp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ser_tx_data_oe,
    input wire logic ser_rx_data_oe,
    input wire logic ser_bit_clk_oe,
    input wire logic ctrl_pin_zero_oe,
    input wire logic ctrl_pin_one_oe,
    input wire logic ctrl_pin_two_oe
);
    // ==========================================================
    // shadow state
    logic [11:0] ctrl_reg; // control as software left it, lock applied
    logic [5:0] dir_reg; // gpio direction
    logic wr_q; // pins lag a landed write by one clock, so skip that cycle
    wire logic wr_ok = pready && pwrite && !pslverr;
    wire logic en = ctrl_reg[SSP_CB_EN];
    wire logic sy = ctrl_reg[SSP_CB_SYNC];
    wire logic [5:0] oe_v = {ctrl_pin_two_oe, ctrl_pin_one_oe, ctrl_pin_zero_oe,
                             ser_bit_clk_oe, ser_rx_data_oe, ser_tx_data_oe};

    // update shadows at the edge that completes a write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= SSP_CTRL_RST;
            dir_reg <= SSP_GPIO_RST;
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr_ok;
            if (wr_ok && paddr == SSP_OFF_CTRL) begin
                ctrl_reg <= en ? (ctrl_reg & SSP_CTRL_LOCK) | (pwdata[11:0] & ~SSP_CTRL_LOCK)
                               : pwdata[11:0];
            end
            if (wr_ok && paddr == SSP_OFF_GPIO_DIR) begin
                dir_reg <= pwdata[5:0];
            end
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence

    chk_apb_wait: assert property (s_setup |=> s_answer)
        else $error("apb answer not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_unmapped_err: assert property (pready && paddr > SSP_OFF_STATUS |-> pslverr)
        else $error("unmapped address not refused");
    chk_tx_driven: assert property (en && !wr_q |-> ser_tx_data_oe)
        else $error("tx data pin not driven");
    chk_rx_quiet: assert property (en && !wr_q |-> !ser_rx_data_oe)
        else $error("rx data pin driven");
    chk_clk_dir: assert property (en && !wr_q |-> ser_bit_clk_oe == ctrl_reg[SSP_CB_CLK_OUT])
        else $error("bit clock direction wrong");
    chk_fs_dir: assert property (en && !wr_q |-> ctrl_pin_two_oe == ctrl_reg[3])
        else $error("frame sync direction wrong");
    chk_zero_dir: assert property (en && !wr_q |->
        ctrl_pin_zero_oe == (sy ? ctrl_reg[6] | ctrl_reg[8] : ctrl_reg[4]))
        else $error("pin zero direction wrong");
    chk_one_dir: assert property (en && !wr_q |->
        ctrl_pin_one_oe == (sy ? ctrl_reg[7] | ctrl_reg[9] : ctrl_reg[5]))
        else $error("pin one direction wrong");
    chk_gpio_dir: assert property (!en && !wr_q |-> oe_v == dir_reg)
        else $error("gpio direction wrong");
endmodule

bind ssp_pin_route ssp_pin_route_assertions ssp_pin_route_assertions_inst (.*);
`default_nettype wire

/* ssp_peer_model.sv */
// behavioural serial codec on the far side of the port
`timescale 1ns/10ps
`default_nettype none

module ssp_peer_model (
    input wire logic clock,
    input wire logic pin_clk,
    input wire logic pin_fs,
    input wire logic pin_tx,
    input wire logic [15:0] rx_word,
    output logic clk_drv,
    output logic fs_drv,
    output logic rx_drv,
    output logic [15:0] cap
);
    // ==========================================================
    // bit tracking, sampled with the system clock
    logic clk_q = 1'b0, fs_q = 1'b0; // last seen pin levels
    int cnt = 0; // bit index, msb first
    initial begin
        clk_drv = 1'b0;
        fs_drv = 1'b0;
        rx_drv = 1'b0;
        cap = 16'h0000;
    end

    // frame sync rising starts a word; data out on rise, tx taken on fall
    always @(posedge clock) begin
        clk_q <= pin_clk;
        fs_q <= pin_fs;
        if (pin_fs && !fs_q) begin
            cnt = 15;
            rx_drv <= rx_word[15];
        end else if (pin_clk && !clk_q) begin
            cnt = (cnt + 15) % 16;
            rx_drv <= rx_word[cnt];
        end
        if (!pin_clk && clk_q) begin
            cap[cnt] <= pin_tx;
        end
    end

    // gated clock: runs for the sixteen bits of one frame only
    task automatic run_frame();
        for (int i = 0; i < 16; i++) begin
            clk_drv = 1'b1;
            fs_drv = (i == 0);
            #80;
            clk_drv = 1'b0;
            #80;
        end
        rx_drv <= ~rx_drv; // released line must not look held
    endtask
endmodule
`default_nettype wire

/* ssp_pin_route_bench.sv */
// self-checking bench for the serial port pin-routing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); end end

module ssp_pin_route_bench;
    import ssp_pkg::*;
    // ==========================================================
    // stimulus and pins
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr;
    wire logic [5:0] out_v, oe_v;
    wire logic [5:0] lvl; // resolved pin levels
    logic [5:0] gp = 6'h00; // outside levels mixed onto undriven pins
    logic [15:0] rx_word = 16'h0000;
    wire logic pclk, pfs, prx;
    wire logic [15:0] cap;
    logic [31:0] rdat;
    logic rerr;
    int fails = 0, cmp_count = 0;
    // a pin shows the port's value while driven, else the far side's
    assign lvl = (oe_v & out_v) | (~oe_v & ({pfs, pfs, pclk, pclk, prx, 1'b0} ^ gp));

    ssp_pin_route ssp_pin_route_inst (
        .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ser_tx_data_in(lvl[0]), .ser_tx_data_out(out_v[0]), .ser_tx_data_oe(oe_v[0]),
        .ser_rx_data_in(lvl[1]), .ser_rx_data_out(out_v[1]), .ser_rx_data_oe(oe_v[1]),
        .ser_bit_clk_in(lvl[2]), .ser_bit_clk_out(out_v[2]), .ser_bit_clk_oe(oe_v[2]),
        .ctrl_pin_zero_in(lvl[3]), .ctrl_pin_zero_out(out_v[3]), .ctrl_pin_zero_oe(oe_v[3]),
        .ctrl_pin_one_in(lvl[4]), .ctrl_pin_one_out(out_v[4]), .ctrl_pin_one_oe(oe_v[4]),
        .ctrl_pin_two_in(lvl[5]), .ctrl_pin_two_out(out_v[5]), .ctrl_pin_two_oe(oe_v[5]));
    ssp_peer_model ssp_peer_model_inst (.clock(clock), .pin_clk(lvl[2]), .pin_fs(lvl[5]),
        .pin_tx(lvl[0]), .rx_word(rx_word), .clk_drv(pclk), .fs_drv(pfs), .rx_drv(prx),
        .cap(cap));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ==========================================================
    // apb master: setup, access until pready, then one idle cycle
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask

    // poll status until a received word is waiting
    task automatic wait_rx();
        int n;
        n = 0;
        do begin
            apb(SSP_OFF_STATUS, 1'b0, 32'h0);
            n++;
        end while (rdat[SSP_SB_RX_FULL] !== 1'b1 && n < 300);
        if (n >= 300) begin
            fails++;
            stop_test();
        end
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        apb(SSP_OFF_DIV, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_000F)
        apb(8'h28, 1'b0, 32'h0);
        `CHK(rerr, 1'b1)
        apb(SSP_OFF_RX, 1'b1, 32'h1234);
        `CHK(rerr, 1'b1)
        $display("test reset done");
        // port unused: pins are plain gpio both ways
        gp <= 6'h2A;
        apb(SSP_OFF_GPIO_DIR, 1'b1, 32'h0F);
        apb(SSP_OFF_GPIO_OUT, 1'b1, 32'h35);
        repeat (4) @(posedge clock);
        `CHK(out_v & 6'h0F, 6'h05)
        apb(SSP_OFF_GPIO_IN, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_0025)
        apb(SSP_OFF_GPIO_DIR, 1'b1, 32'h0);
        repeat (4) @(posedge clock);
        apb(SSP_OFF_GPIO_IN, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_002A)
        $display("test gpio done");
        // sync mode, port makes clock and frame sync, flag 0 out high, flag 1 in
        gp <= 6'h10;
        rx_word <= 16'hC3A5;
        apb(SSP_OFF_DIV, 1'b1, 32'h7);
        apb(SSP_OFF_TX0, 1'b1, 32'hB61D);
        apb(SSP_OFF_CTRL, 1'b1, 32'h50F);
        wait_rx();
        apb(SSP_OFF_RX, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_C3A5)
        `CHK(cap, 16'hB61D)
        `CHK(out_v[SSP_PIN_C0], 1'b1)
        apb(SSP_OFF_STATUS, 1'b0, 32'h0);
        `CHK(rdat[SSP_SB_FLAG1_IN], 1'b1)
        apb(SSP_OFF_CTRL, 1'b1, 32'h0F0);
        apb(SSP_OFF_CTRL, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_010E)
        apb(SSP_OFF_CTRL, 1'b1, 32'h0);
        apb(SSP_OFF_CTRL, 1'b0, 32'h0);
        `CHK(rdat, 32'h0)
        $display("test sync done");
        // async mode, far side makes a gated clock and both frame syncs
        gp <= 6'h00;
        rx_word <= 16'h3C96;
        apb(SSP_OFF_TX0, 1'b1, 32'h5A0F);
        apb(SSP_OFF_CTRL, 1'b1, 32'h001);
        #1.3;
        ssp_peer_model_inst.run_frame();
        repeat (10) @(posedge clock);
        apb(SSP_OFF_RX, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_3C96)
        `CHK(cap, 16'h5A0F)
        $display("test async done");
        stop_test();
    end

    // hang guard
    initial begin
        #400000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
